// ### hdl/uira_pkg.sv
// package of the indirect core register access bridge: offsets, fields, resets, targets
// assumes one system clock shared by the special-function-register bus and the core
// How it works
// - writing busy as one starts a core read; writing zero does nothing
// - busy reads one while a read runs, zero once data is valid
// - with auto-read set, reading data starts the next read by itself
// - address field is the low six bits, read and write, 64 locations
// - data register writes go to the address in the field; data reads return the value last captured or written
// - software reads: wait, load address and set busy, wait, read data
// - interrupt flags for in, out and common sit at 0x02, 0x04, 0x06
// - interrupt enables for in, out and common sit at 0x07, 0x09, 0x0b
// - function address 0x00, power 0x01, frame low 0x0c, frame high 0x0d
// - endpoint index 0x0e, clock recovery 0x0f, endpoint enable 0x1e
// - indexed ep0 control 0x11, out control low 0x14, high 0x15
// - indexed 0x16 gives ep0 byte count, 0x17 out packet count high
// - index upper four bits read zero and ignore writes
// - four-bit select picks endpoint 0 to 3, other codes reserved
// - core addresses 0x20 to 0x23 reach the four endpoint fifos
package uira_pkg;
   localparam logic [7:0] SFR_ADDR_OFS = 8'h96;
   localparam logic [7:0] SFR_DATA_OFS = 8'h97;
   localparam int BUSY_BIT = 7;
   localparam int AUTO_BIT = 6;
   localparam int ADDR_MSB = 5;
   localparam int EPSEL_MSB = 3;
   localparam logic [5:0] ADDR_RESET = 6'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] EPSEL_RESET = 4'h0;
   localparam logic [3:0] EPSEL_ZERO = 4'h0;
   localparam logic [3:0] EPSEL_LAST = 4'h3;
   localparam logic [5:0] CA_FUNCTION_ADDRESS_REG = 6'h00;
   localparam logic [5:0] CA_POWER = 6'h01;
   localparam logic [5:0] CA_IN_IRQ = 6'h02;
   localparam logic [5:0] CA_OUT_IRQ = 6'h04;
   localparam logic [5:0] CA_CM_IRQ = 6'h06;
   localparam logic [5:0] CA_IN_IE = 6'h07;
   localparam logic [5:0] CA_OUT_IE = 6'h09;
   localparam logic [5:0] CA_CM_IE = 6'h0b;
   localparam logic [5:0] CA_FRAME_LO = 6'h0c;
   localparam logic [5:0] CA_FRAME_HI = 6'h0d;
   localparam logic [5:0] CA_INDEX = 6'h0e;
   localparam logic [5:0] CA_CLOCK_RECOVERY_CTRL = 6'h0f;
   localparam logic [5:0] CA_CSR0 = 6'h11;
   localparam logic [5:0] CA_IN_CSR_HI = 6'h12;
   localparam logic [5:0] CA_OUT_CSR_LO = 6'h14;
   localparam logic [5:0] CA_OUT_CSR_HI = 6'h15;
   localparam logic [5:0] CA_CNT0 = 6'h16;
   localparam logic [5:0] CA_OUT_CNT_HI = 6'h17;
   localparam logic [5:0] CA_ENDPOINT_ENABLE_REG = 6'h1e;
   localparam logic [5:0] CA_FIFO0 = 6'h20;
   localparam logic [5:0] CA_FIFO3 = 6'h23;

   typedef enum logic [4:0] {
      UIRA_T_NONE = 5'h00,
      UIRA_T_FUNCTION_ADDRESS_REG = 5'h01,
      UIRA_T_POWER = 5'h02,
      UIRA_T_IN_IRQ = 5'h03,
      UIRA_T_OUT_IRQ = 5'h04,
      UIRA_T_CM_IRQ = 5'h05,
      UIRA_T_IN_IE = 5'h06,
      UIRA_T_OUT_IE = 5'h07,
      UIRA_T_CM_IE = 5'h08,
      UIRA_T_FRAME_LO = 5'h09,
      UIRA_T_FRAME_HI = 5'h0a,
      UIRA_T_INDEX = 5'h0b,
      UIRA_T_CLOCK_RECOVERY_CTRL = 5'h0c,
      UIRA_T_ENDPOINT_ENABLE_REG = 5'h0d,
      UIRA_T_FIFO = 5'h0e,
      UIRA_T_EP0_CSR = 5'h0f,
      UIRA_T_IN_CSR_LO = 5'h10,
      UIRA_T_IN_CSR_HI = 5'h11,
      UIRA_T_OUT_CSR_LO = 5'h12,
      UIRA_T_OUT_CSR_HI = 5'h13,
      UIRA_T_EP0_CNT = 5'h14,
      UIRA_T_OUT_CNT_LO = 5'h15,
      UIRA_T_OUT_CNT_HI = 5'h16
   } uira_target_t;

   typedef enum logic [0:0] {
      UIRA_S_IDLE = 1'b0,
      UIRA_S_WAIT = 1'b1
   } uira_state_t;
endpackage

// ### hdl/uira_dec_if.sv
// interface between the bridge and its core address decoder
// assumes both ends run on the bridge clock
`timescale 1ns/10ps
interface uira_dec_if;
   import uira_pkg::*;
   logic [5:0] addr;
   logic wr;
   logic [7:0] wdata;
   uira_target_t target;
   logic [3:0] epsel;
   logic local_hit;
   logic [7:0] local_data;
   modport bridge (output addr, output wr, output wdata,
                   input target, input epsel, input local_hit, input local_data);
   modport decoder (input addr, input wr, input wdata,
                    output target, output epsel, output local_hit, output local_data);
endinterface

// ### hdl/uira_decode.sv
// core address decoder and endpoint index register
// assumes addr, wr and wdata come from the bridge on the same clock
`timescale 1ns/10ps
module uira_decode (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bridge side
   uira_dec_if.decoder dec
);
   import uira_pkg::*;

   logic [3:0] endpoint_select_field;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         endpoint_select_field <= EPSEL_RESET;
      end else if (dec.wr && dec.addr == CA_INDEX) begin
         endpoint_select_field <= dec.wdata[EPSEL_MSB:0];
      end
   end

   logic ep_zero;
   assign ep_zero = (endpoint_select_field == EPSEL_ZERO);
   assign dec.epsel = endpoint_select_field;
   assign dec.local_hit = (dec.addr == CA_INDEX);
   assign dec.local_data = {4'h0, endpoint_select_field};

   always_comb begin
      dec.target = UIRA_T_NONE;
      if (dec.addr == CA_IN_IRQ) begin
         dec.target = UIRA_T_IN_IRQ;
      end else if (dec.addr == CA_OUT_IRQ) begin
         dec.target = UIRA_T_OUT_IRQ;
      end else if (dec.addr == CA_CM_IRQ) begin
         dec.target = UIRA_T_CM_IRQ;
      end else if (dec.addr == CA_IN_IE) begin
         dec.target = UIRA_T_IN_IE;
      end else if (dec.addr == CA_OUT_IE) begin
         dec.target = UIRA_T_OUT_IE;
      end else if (dec.addr == CA_CM_IE) begin
         dec.target = UIRA_T_CM_IE;
      end else if (dec.addr == CA_FUNCTION_ADDRESS_REG) begin
         dec.target = UIRA_T_FUNCTION_ADDRESS_REG;
      end else if (dec.addr == CA_POWER) begin
         dec.target = UIRA_T_POWER;
      end else if (dec.addr == CA_FRAME_LO) begin
         dec.target = UIRA_T_FRAME_LO;
      end else if (dec.addr == CA_FRAME_HI) begin
         dec.target = UIRA_T_FRAME_HI;
      end else if (dec.addr == CA_INDEX) begin
         dec.target = UIRA_T_INDEX;
      end else if (dec.addr == CA_CLOCK_RECOVERY_CTRL) begin
         dec.target = UIRA_T_CLOCK_RECOVERY_CTRL;
      end else if (dec.addr == CA_ENDPOINT_ENABLE_REG) begin
         dec.target = UIRA_T_ENDPOINT_ENABLE_REG;
      end else if (dec.addr >= CA_FIFO0 && dec.addr <= CA_FIFO3) begin
         dec.target = UIRA_T_FIFO;
      end else if (dec.addr == CA_CSR0) begin
         // endpoint 0 control shares its slot with the in control low byte
         dec.target = ep_zero ? UIRA_T_EP0_CSR : UIRA_T_IN_CSR_LO;
      end else if (dec.addr == CA_IN_CSR_HI) begin
         dec.target = UIRA_T_IN_CSR_HI;
      end else if (dec.addr == CA_OUT_CSR_LO) begin
         dec.target = UIRA_T_OUT_CSR_LO;
      end else if (dec.addr == CA_OUT_CSR_HI) begin
         dec.target = UIRA_T_OUT_CSR_HI;
      end else if (dec.addr == CA_CNT0) begin
         dec.target = ep_zero ? UIRA_T_EP0_CNT : UIRA_T_OUT_CNT_LO;
      end else if (dec.addr == CA_OUT_CNT_HI) begin
         dec.target = UIRA_T_OUT_CNT_HI;
      end
   end
endmodule

// ### hdl/uira_bridge.sv
// indirect core register access bridge: address/control and data registers
// assumes the special-function-register bus and the core share clk; core answers reads
// with core_ack some cycles after core_rd, core_rdata valid in that cycle
`timescale 1ns/10ps
module uira_bridge (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // special-function-register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // core register port
   output logic [5:0] core_addr,
   output uira_pkg::uira_target_t core_target,
   output logic [3:0] core_ep,
   output logic core_wr,
   output logic core_rd,
   output logic [7:0] core_wdata,
   input wire logic core_ack,
   input wire logic [7:0] core_rdata
);
   import uira_pkg::*;

   uira_dec_if dec ();

   uira_decode u_decode (
      .clk(clk),
      .nrst(nrst),
      .dec(dec)
   );

   logic [5:0] core_reg_addr_field;
   logic auto_read_enable;
   logic busy;
   logic [7:0] core_indirect_data;
   uira_state_t state;

   logic hit_addr;
   logic hit_data;
   logic wr_addr;
   logic wr_data;
   logic rd_data;
   logic start_read;
   logic [5:0] next_addr;
   logic local_done;

   assign hit_addr = (sfr_addr == SFR_ADDR_OFS);
   assign hit_data = (sfr_addr == SFR_DATA_OFS);
   assign wr_addr = sfr_wr && hit_addr;
   assign wr_data = sfr_wr && hit_data;
   assign rd_data = sfr_rd && hit_data;
   // address and trigger may come in one write
   assign next_addr = wr_addr ? sfr_wdata[ADDR_MSB:0] : core_reg_addr_field;
   // a trigger while a read is already running is dropped
   assign start_read = (state == UIRA_S_IDLE) &&
                       ((wr_addr && sfr_wdata[BUSY_BIT]) ||
                        (rd_data && auto_read_enable));

   // decoder sees the address of the access now being issued
   assign dec.addr = next_addr;
   assign dec.wr = wr_data && (state == UIRA_S_IDLE);
   assign dec.wdata = sfr_wdata;
   assign local_done = (state == UIRA_S_WAIT) && (core_target == UIRA_T_INDEX);

   // address/control register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_reg_addr_field <= ADDR_RESET;
         auto_read_enable <= 1'b0;
      end else if (wr_addr) begin
         core_reg_addr_field <= sfr_wdata[ADDR_MSB:0];
         auto_read_enable <= sfr_wdata[AUTO_BIT];
      end
   end

   // read sequencing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= UIRA_S_IDLE;
         busy <= 1'b0;
      end else begin
         case (state)
            UIRA_S_IDLE: begin
               if (start_read) begin
                  state <= UIRA_S_WAIT;
                  busy <= 1'b1;
               end
            end
            UIRA_S_WAIT: begin
               if (core_ack || local_done) begin
                  state <= UIRA_S_IDLE;
                  busy <= 1'b0;
               end
            end
            default: begin
               state <= UIRA_S_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // data register: captured read value, or the value last written
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_indirect_data <= DATA_RESET;
      end else if (local_done) begin
         core_indirect_data <= dec.local_data;
      end else if (state == UIRA_S_WAIT && core_ack) begin
         core_indirect_data <= core_rdata;
      end else if (dec.wr) begin
         core_indirect_data <= sfr_wdata;
      end
   end

   // core port, registered at issue
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_addr <= ADDR_RESET;
         core_target <= UIRA_T_NONE;
         core_ep <= EPSEL_RESET;
         core_wr <= 1'b0;
         core_rd <= 1'b0;
         core_wdata <= DATA_RESET;
      end else begin
         core_wr <= dec.wr;
         core_rd <= start_read && !dec.local_hit;
         if (dec.wr || start_read) begin
            core_addr <= next_addr;
            core_target <= dec.target;
            core_ep <= dec.epsel;
            core_wdata <= sfr_wdata;
         end
      end
   end

   // bus read data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= DATA_RESET;
      end else if (sfr_rd && hit_addr) begin
         sfr_rdata <= {busy, auto_read_enable, core_reg_addr_field};
      end else if (rd_data) begin
         sfr_rdata <= core_indirect_data;
      end else if (sfr_rd) begin
         sfr_rdata <= DATA_RESET;
      end
   end
endmodule

// ### sim/uira_bridge_sva.sv
// port checker of the indirect core register bridge
// assumes one clock and an async active-low reset
`timescale 1ns/10ps
module uira_bridge_chk (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // core port
   input wire logic [5:0] core_addr,
   input wire logic core_wr,
   input wire logic core_rd,
   input wire logic [7:0] core_wdata,
   input wire logic core_ack,
   input wire logic [7:0] core_rdata
);
   logic pend, quiet, dval, af;
   logic [5:0] fld;
   logic [7:0] dreg;
   wire aw = sfr_wr && sfr_addr == 8'h96;
   wire dw = sfr_wr && sfr_addr == 8'h97;
   wire ar = sfr_rd && sfr_addr == 8'h96;
   wire calm = !pend && !core_rd && quiet;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // read outstanding, and whether the last cycle carried a strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend <= 1'b0;
         quiet <= 1'b0;
      end else begin
         pend <= core_rd || (pend && !core_ack);
         quiet <= !(sfr_wr || sfr_rd);
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fld <= 6'h00;
         af <= 1'b0;
      end else if (aw) begin
         fld <= sfr_wdata[5:0];
         af <= sfr_wdata[6];
      end
   end
   // data register content, valid only when known from the port side
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dval <= 1'b1;
         dreg <= 8'h00;
      end else if (core_ack && pend) begin
         dval <= 1'b1;
         dreg <= core_rdata;
      // an auto-read data read may refill the register from the index slot
      end else if ((aw && sfr_wdata[7]) || dw || (sfr_rd && sfr_addr == 8'h97 && af)) begin
         dval <= 1'b0;
      end
   end
   a_trig_reads: assert property (aw && sfr_wdata[7] && sfr_wdata[5:0] != 6'h0e
      && calm |=> core_rd && core_addr == $past(sfr_wdata[5:0]))
      else $error("trigger did not start a core read");
   a_zero_idle: assert property (aw && !sfr_wdata[7] && calm |=> !core_rd)
      else $error("busy write of zero started a read");
   a_data_route: assert property (dw && calm |=> core_wr && core_addr == $past(fld)
      && core_wdata == $past(sfr_wdata))
      else $error("data write not routed to field address");
   a_one_read: assert property (pend |-> !core_rd)
      else $error("second read issued while busy");
   a_busy_high: assert property (ar && pend |=> sfr_rdata[7])
      else $error("busy read low during a read");
   a_busy_low: assert property (ar && calm |=> !sfr_rdata[7])
      else $error("busy read high while idle");
   a_data_hold: assert property (sfr_rd && sfr_addr == 8'h97 && dval
      |=> sfr_rdata == $past(dreg))
      else $error("data register lost captured value");
   a_field_back: assert property (ar |=> sfr_rdata[5:0] == $past(fld))
      else $error("address field readback wrong");
endmodule
bind uira_bridge uira_bridge_chk chk_u (
   .clk(clk),
   .nrst(nrst),
   .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata),
   .core_addr(core_addr),
   .core_wr(core_wr),
   .core_rd(core_rd),
   .core_wdata(core_wdata),
   .core_ack(core_ack),
   .core_rdata(core_rdata)
);

// ### sim/uira_core_model.sv
// behavioural core register file on the far side of the bridge
// assumes lat is at least one; rdata toggles when not answering
`timescale 1ns/10ps
module uira_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // core port
   input wire logic [5:0] core_addr,
   input wire logic [3:0] core_ep,
   input wire logic core_wr,
   input wire logic core_rd,
   input wire logic [7:0] core_wdata,
   output logic core_ack,
   output logic [7:0] core_rdata,
   // answer delay
   input wire logic [3:0] lat
);
   logic [7:0] mem [256];
   logic [3:0] cnt;
   wire [7:0] key = {core_ep[1:0] & {2{core_addr[5:3] == 3'h2}}, core_addr};
   always_ff @(posedge clk) begin
      if (core_wr) mem[key] <= core_wdata;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         core_ack <= 1'b0;
         core_rdata <= 8'h00;
      end else begin
         core_ack <= cnt == 4'h1;
         core_rdata <= (cnt == 4'h1) ? mem[key] : ~core_rdata;
         cnt <= core_rd ? lat : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
      end
   end
endmodule

// ### sim/usb_core_indirect_reg_access_tb.sv
// self-checking bench of the indirect core register bridge
// assumes the core model raises core_ack lat plus one cycles after each core_rd
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module usb_core_indirect_reg_access_tb;
   import uira_pkg::*;
   logic clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, core_ack, core_wr, core_rd;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, core_rdata, core_wdata, r, d;
   logic [5:0] core_addr;
   logic [3:0] core_ep, lat = 1;
   uira_target_t core_target;
   logic [7:0] ref_mem [256];
   logic [5:0] al [21] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h09,
      6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1e,
      6'h20, 6'h23};
   int miscompares = 0, n_tests = 0, cyc = 0;
   always #4 clk = ~clk;
   uira_bridge dut_u (
      .clk(clk),
      .nrst(nrst),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .core_addr(core_addr),
      .core_target(core_target),
      .core_ep(core_ep),
      .core_wr(core_wr),
      .core_rd(core_rd),
      .core_wdata(core_wdata),
      .core_ack(core_ack),
      .core_rdata(core_rdata)
   );
   uira_core_model core_u (
      .clk(clk),
      .nrst(nrst),
      .core_addr(core_addr),
      .core_ep(core_ep),
      .core_wr(core_wr),
      .core_rd(core_rd),
      .core_wdata(core_wdata),
      .core_ack(core_ack),
      .core_rdata(core_rdata),
      .lat(lat)
   );
   function automatic logic [7:0] kf(input logic [5:0] a, input logic [3:0] e);
      return {e[1:0] & {2{a[5:3] == 3'h2}}, a};
   endfunction
   function automatic uira_target_t tgt(input logic [5:0] a, input logic [3:0] e);
      case (a)
         6'h00: return UIRA_T_FUNCTION_ADDRESS_REG;
         6'h01: return UIRA_T_POWER;
         6'h02: return UIRA_T_IN_IRQ;
         6'h04: return UIRA_T_OUT_IRQ;
         6'h06: return UIRA_T_CM_IRQ;
         6'h07: return UIRA_T_IN_IE;
         6'h09: return UIRA_T_OUT_IE;
         6'h0b: return UIRA_T_CM_IE;
         6'h0c: return UIRA_T_FRAME_LO;
         6'h0d: return UIRA_T_FRAME_HI;
         6'h0f: return UIRA_T_CLOCK_RECOVERY_CTRL;
         6'h11: return (e == 0) ? UIRA_T_EP0_CSR : UIRA_T_IN_CSR_LO;
         6'h12: return UIRA_T_IN_CSR_HI;
         6'h14: return UIRA_T_OUT_CSR_LO;
         6'h15: return UIRA_T_OUT_CSR_HI;
         6'h16: return (e == 0) ? UIRA_T_EP0_CNT : UIRA_T_OUT_CNT_LO;
         6'h17: return UIRA_T_OUT_CNT_HI;
         6'h1e: return UIRA_T_ENDPOINT_ENABLE_REG;
         6'h20, 6'h23: return UIRA_T_FIFO;
         default: return UIRA_T_NONE;
      endcase
   endfunction
   task automatic finish_test;
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one bus cycle; read data lands in r
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1;
      sfr_wr = w;
      sfr_rd = !w;
      sfr_addr = a;
      sfr_wdata = v;
      @(posedge clk);
      #1;
      sfr_wr = 0;
      sfr_rd = 0;
      r = sfr_rdata;
   endtask
   task automatic idle;
      int k = 0;
      do begin
         acc(0, 8'h96, 8'h00);
         k++;
      end while (r[7] !== 1'b0 && k < 50);
      `CHK(r[7], 1'b0)
   endtask
   task automatic rd_core(input logic [5:0] a, input logic [7:0] e);
      idle();
      acc(1, 8'h96, {2'b10, a});
      idle();
      acc(0, 8'h97, 8'h00);
      `CHK(r, e)
   endtask
   task automatic wr_core(input logic [5:0] a, input logic [7:0] v);
      idle();
      acc(1, 8'h96, {2'b00, a});
      acc(1, 8'h97, v);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(55));
      repeat (4) @(posedge clk);
      #1 nrst = 1;
      acc(0, 8'h96, 8'h00);
      `CHK(r, 8'h00)
      acc(0, 8'h97, 8'h00);
      `CHK(r, 8'h00)
      acc(1, 8'h96, 8'h7f);
      acc(0, 8'h96, 8'h00);
      `CHK(r, 8'h7f)
      for (int e = 0; e < 4; e++) begin
         wr_core(6'h0e, {4'($urandom), 4'(e)});
         rd_core(6'h0e, {4'h0, 4'(e)});
         `CHK(core_ep, 4'(e))
         foreach (al[i]) begin
            d = 8'($urandom);
            wr_core(al[i], d);
            `CHK(core_target, tgt(al[i], 4'(e)))
            ref_mem[kf(al[i], 4'(e))] = d;
         end
      end
      for (int e = 0; e < 4; e++) begin
         wr_core(6'h0e, 8'(e));
         foreach (al[i]) begin
            lat = 4'(1 + $urandom % 8);
            rd_core(al[i], ref_mem[kf(al[i], 4'(e))]);
         end
      end
      wr_core(6'h0e, 8'h0c);
      rd_core(6'h0e, 8'h0c);
      `CHK(core_ep, 4'hc)
      // a data write while a slow read runs is dropped
      lat = 4'hf;
      acc(1, 8'h96, 8'h81);
      acc(1, 8'h97, 8'h5a);
      idle();
      acc(0, 8'h97, 8'h00);
      `CHK(r, ref_mem[8'h01])
      rd_core(6'h01, ref_mem[8'h01]);
      // auto-read: each data read starts the next read
      lat = 4'h4;
      acc(1, 8'h96, 8'hc0);
      idle();
      acc(0, 8'h97, 8'h00);
      `CHK(r, ref_mem[8'h00])
      acc(0, 8'h96, 8'h00);
      `CHK(r[7], 1'b1)
      idle();
      acc(0, 8'h97, 8'h00);
      `CHK(r, ref_mem[8'h00])
      acc(1, 8'h96, 8'h00);
      // reset in mid-run with a read still outstanding
      @(posedge clk);
      #1 nrst = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      acc(0, 8'h96, 8'h00);
      `CHK(r, 8'h00)
      acc(0, 8'h97, 8'h00);
      `CHK(r, 8'h00)
      rd_core(6'h0e, 8'h00);
      finish_test();
   end
endmodule
